// ==== dv/gpio_ports_assertions.sv ====
// ------------------------------------------------
// port block bus and pin checks
// ------------------------------------------------
module gpio_ports_assertions (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // apb slave side
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // pin side
  input wire logic [7:0] port0_out_o,
  input wire logic [7:0] port0_oe_n_o,
  input wire logic [5:0] port1_out_o,
  input wire logic [5:0] port1_oe_n_o,
  input wire logic external_interrupt_zero_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  // setup then access phase of one transfer
  sequence s_setup;
    psel_i && !penable_i && !pready_o;
  endsequence
  sequence s_access;
    psel_i && penable_i;
  endsequence

  property p_answer;
    s_setup ##1 s_access |=> pready_o;
  endproperty
  property p_pulse;
    pready_o |=> !pready_o;
  endproperty
  property p_reset_vals;
    $rose(rstn_i) |-> port0_out_o == 8'hFF && port1_out_o == 6'h00 && port1_oe_n_o == 6'h3F;
  endproperty
  property p_p0_hold;
    $changed(port0_out_o) |->
      $past(pready_o && pwrite_i && (paddr_i == 12'h000 || paddr_i == 12'h018));
  endproperty
  property p_p1_hold;
    $changed(port1_out_o) |->
      $past(pready_o && pwrite_i && (paddr_i == 12'h00C || paddr_i == 12'h018));
  endproperty
  property p_dir_hold;
    $changed(port1_oe_n_o) |-> $past(pready_o && pwrite_i && paddr_i == 12'h010);
  endproperty
  property p_latch_read;
    pready_o && !pwrite_i && paddr_i == 12'h000 |-> prdata_o == {24'h000000, port0_out_o};
  endproperty
  property p_dir_read;
    pready_o && !pwrite_i && paddr_i == 12'h010 |-> prdata_o == {26'h0, ~port1_oe_n_o};
  endproperty
  property p_open_drain;
    (~port0_oe_n_o & port0_out_o) == 8'h00;
  endproperty
  property p_int_pin;
    external_interrupt_zero_o |-> port0_oe_n_o[0];
  endproperty

  a_answer: assert property (p_answer) else $error("no answer one cycle after access");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset outputs");
  a_p0_hold: assert property (p_p0_hold) else $error("first latch moved unwritten");
  a_p1_hold: assert property (p_p1_hold) else $error("second latch moved unwritten");
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved unwritten");
  a_latch_read: assert property (p_latch_read) else $error("latch read mismatch");
  a_dir_read: assert property (p_dir_read) else $error("direction read mismatch");
  a_open_drain: assert property (p_open_drain) else $error("drive high on open drain");
  a_int_pin: assert property (p_int_pin) else $error("bit zero driven in int mode");
endmodule

bind gpio_ports gpio_ports_assertions i_chk (
  .clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .port0_out_o(port0_out_o),
  .port0_oe_n_o(port0_oe_n_o),
  .port1_out_o(port1_out_o),
  .port1_oe_n_o(port1_oe_n_o),
  .external_interrupt_zero_o(external_interrupt_zero_o)
);

// ==== dv/gpio_ports_tb_top.sv ====
module gpio_ports_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic chk; logic [31:0] data; logic err;} exp_t;
  logic clk_sys_i = 1'h0;
  logic rstn_i = 1'h0;
  logic psel_i = 1'h0;
  logic penable_i = 1'h0;
  logic pwrite_i = 1'h0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'hF;
  logic [7:0] board0 = 8'hFF;
  logic [5:0] board1 = 6'h00;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, external_interrupt_zero_o;
  logic [7:0] port0_out_o, port0_oe_n_o, pin0;
  logic [5:0] port1_out_o, port1_oe_n_o, pin1;
  exp_t exp_q[$];
  exp_t e;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;

  gpio_ports i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .port0_pin_i(pin0), .port0_out_o(port0_out_o), .port0_oe_n_o(port0_oe_n_o),
    .port1_pin_i(pin1), .port1_out_o(port1_out_o), .port1_oe_n_o(port1_oe_n_o),
    .external_interrupt_zero_o(external_interrupt_zero_o));
  port_pads i_pads (.port0_out_i(port0_out_o), .port0_oe_n_i(port0_oe_n_o),
    .port1_out_i(port1_out_o), .port1_oe_n_i(port1_oe_n_o), .board0_i(board0),
    .board1_i(board1), .pin0_o(pin0), .pin1_o(pin1));

  // ------------------------------------------------
  // clock, timeout, checks
  // ------------------------------------------------
  always #10 clk_sys_i = ~clk_sys_i;

  task automatic final_report();
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask

  // one apb transfer; for reads d is the expected data
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic ee);
    @(posedge clk_sys_i);
    psel_i <= 1'h1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    exp_q.push_back('{~wr, d, ee});
    @(posedge clk_sys_i);
    penable_i <= 1'h1;
    do @(posedge clk_sys_i); while (pready_o !== 1'h1);
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask

  // timeout ceiling well above the sequence length
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      final_report();
    end
  end

  // completed transfers against the oldest note
  always @(posedge clk_sys_i) begin
    if (psel_i && penable_i && pready_o === 1'h1) begin
      e = exp_q.pop_front();
      cmp_bit(pslverr_o, e.err);
      if (e.chk) cmp_word(prdata_o, e.data);
    end
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    logic [7:0] r;
    logic [5:0] a, d, v, m;
    logic [2:0] i;
    void'($urandom(52388));
    r = 8'($urandom);
    a = 6'($urandom);
    d = 6'($urandom);
    board1 <= 6'($urandom);
    repeat (10) @(posedge clk_sys_i);
    rstn_i <= 1'h1;
    bus(1'h0, 12'h000, 32'hFF, 1'h0);
    bus(1'h0, 12'h010, 32'h0, 1'h0);
    bus(1'h0, 12'h014, 32'h0, 1'h0);
    bus(1'h0, 12'h00C, {26'h0, board1}, 1'h0);
    cmp_word({26'h0, port1_out_o}, 32'h0);
    bus(1'h1, 12'h000, {24'h0, r}, 1'h0);
    @(negedge clk_sys_i);
    cmp_word({24'h0, port0_out_o}, {24'h0, r});
    bus(1'h0, 12'h000, {24'h0, r}, 1'h0);
    pstrb_i <= 4'hE;
    bus(1'h1, 12'h000, {24'h0, ~r}, 1'h0);
    pstrb_i <= 4'hF;
    bus(1'h0, 12'h000, {24'h0, r}, 1'h0);
    board0 <= 8'($urandom);
    repeat (5) @(posedge clk_sys_i);
    bus(1'h0, 12'h008, {24'h0, board0 & r}, 1'h0);
    bus(1'h1, 12'h008, 32'h0, 1'h1);
    bus(1'h0, 12'h0FC, 32'h0, 1'h1);
    bus(1'h1, 12'h00C, {26'h0, a}, 1'h0);
    @(negedge clk_sys_i);
    cmp_word({26'h0, port1_out_o}, {26'h0, a});
    bus(1'h1, 12'h010, {26'h0, d}, 1'h0);
    @(negedge clk_sys_i);
    cmp_word({26'h0, port1_oe_n_o}, {26'h0, ~d});
    bus(1'h0, 12'h00C, {26'h0, (d & a) | (~d & board1)}, 1'h0);
    for (int k = 1; k < 4; k++) begin
      i = 3'($urandom_range(5, 0));
      m = 6'h01 << i;
      v = (d & a) | (~d & board1);
      a = (k == 1) ? (v | m) : (k == 2) ? (v & ~m) : (v ^ m);
      bus(1'h1, 12'h018, {26'h0, 1'h1, 2'(k), i}, 1'h0);
      bus(1'h1, 12'h010, 32'h3F, 1'h0);
      bus(1'h0, 12'h00C, {26'h0, a}, 1'h0);
      bus(1'h1, 12'h010, {26'h0, d}, 1'h0);
      repeat (3) @(posedge clk_sys_i);
    end
    bus(1'h1, 12'h014, 32'h1, 1'h0);
    @(negedge clk_sys_i);
    cmp_bit(port0_oe_n_o[0], 1'h1);
    bus(1'h0, 12'h014, 32'h1, 1'h0);
    for (int k = 0; k < 2; k++) begin
      board0[0] <= ~k[0];
      repeat (5) @(posedge clk_sys_i);
      cmp_bit(external_interrupt_zero_o, ~k[0]);
    end
    bus(1'h1, 12'h014, 32'h0, 1'h0);
    repeat (3) @(posedge clk_sys_i);
    final_report();
  end
endmodule

// ==== dv/port_pads.sv ====
// ------------------------------------------------
// board pads: resolve pin levels
// ------------------------------------------------
module port_pads (
  // device drive
  input wire logic [7:0] port0_out_i,
  input wire logic [7:0] port0_oe_n_i,
  input wire logic [5:0] port1_out_i,
  input wire logic [5:0] port1_oe_n_i,
  // board levels where the device lets go
  input wire logic [7:0] board0_i,
  input wire logic [5:0] board1_i,
  // resolved pins
  output logic [7:0] pin0_o,
  output logic [5:0] pin1_o
);
  // open drain pulls low, else board level
  assign pin0_o = board0_i & (port0_oe_n_i | port0_out_i);
  // push-pull output bits win over board
  assign pin1_o = (port1_oe_n_i & board1_i) | (~port1_oe_n_i & port1_out_i);
endmodule

// ==== rtl/gpio_pkg.sv ====
package gpio_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // ---------------------------------------------------------------
  // port widths and synchroniser depth
  // ---------------------------------------------------------------
  localparam int unsigned PORT0_W = 8;
  localparam int unsigned PORT1_W = 6;
  localparam int unsigned SYNC_STAGES = 2;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] PORT0_OUTPUT_LATCH_OFS = 12'h000;
  localparam logic [11:0] PORT0_PIN_INPUT_OFS = 12'h008;
  localparam logic [11:0] PORT1_OUTPUT_LATCH_OFS = 12'h00C;
  localparam logic [11:0] PORT1_DIRECTION_CONTROL_OFS = 12'h010;
  localparam logic [11:0] EXT_INT_CONTROL_OFS = 12'h014;
  localparam logic [11:0] BIT_OP_OFS = 12'h018;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PORT0_LATCH_RST = 8'hFF;
  localparam logic [5:0] PORT1_LATCH_RST = 6'h00;
  localparam logic [5:0] PORT1_DIR_RST = 6'h00;
  localparam logic EXT_EXTERNAL_INTERRUPT_ZERO_EN_RST = 1'b0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned EXT_EXTERNAL_INTERRUPT_ZERO_EN_BIT = 0;
  localparam int unsigned BIT_OP_IDX_LSB = 0;
  localparam int unsigned BIT_OP_CODE_LSB = 3;
  localparam int unsigned BIT_OP_PORT_BIT = 5;

  // bit operation codes
  localparam logic [1:0] BIT_OP_SET = 2'h1;
  localparam logic [1:0] BIT_OP_CLEAR = 2'h2;
  localparam logic [1:0] BIT_OP_TOGGLE = 2'h3;

  // ---------------------------------------------------------------
  // bus sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_UPDATE = 3'b100
  } bus_state_t;

endpackage

// ==== rtl/gpio_ports.sv ====
// Local design decision: the APB register port.
module gpio_ports (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // first port pins, open drain
  input wire logic [7:0] port0_pin_i,
  output logic [7:0] port0_out_o,
  output logic [7:0] port0_oe_n_o,
  // second port pins, push-pull
  input wire logic [5:0] port1_pin_i,
  output logic [5:0] port1_out_o,
  output logic [5:0] port1_oe_n_o,
  // external interrupt zero level toward the interrupt controller
  output logic external_interrupt_zero_o
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0] pins0_sync;
  logic [5:0] pins1_sync;
  // pin changes reach the snapshot three edges late at the earliest

  // first port pins into the clock domain
  pin_sync #(
    .WIDTH(gpio_pkg::PORT0_W)
  ) u_sync0 (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .pin_i(port0_pin_i),
    .sync_o(pins0_sync)
  );

  // second port pins into the clock domain
  pin_sync #(
    .WIDTH(gpio_pkg::PORT1_W)
  ) u_sync1 (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .pin_i(port1_pin_i),
    .sync_o(pins1_sync)
  );

  // ---------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------
  gpio_pkg::bus_state_t state_q, state_d;
  logic [7:0] snap0_q, snap0_d;
  logic [5:0] snap1_q, snap1_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [7:0] lat0_q, lat0_d;
  logic [5:0] lat1_q, lat1_d;
  logic [5:0] dir1_q, dir1_d;
  logic external_interrupt_zero_en_q, external_interrupt_zero_en_d;
  logic [7:0] oe0_n_q, oe0_n_d;
  logic [5:0] oe1_n_q, oe1_n_d;
  logic external_interrupt_zero_q, external_interrupt_zero_d;

  // ---------------------------------------------------------------
  // read views
  // ---------------------------------------------------------------
  logic [5:0] port1_view;
  logic [31:0] rd_word;
  logic addr_hit;
  logic addr_ro;

  // second port read: pins for inputs, latch for outputs
  assign port1_view = (snap1_q & ~dir1_q) | (lat1_q & dir1_q);

  // address decode and read mux, unused upper bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    addr_hit = 1'b1;
    addr_ro = 1'b0;
    if (paddr_i == gpio_pkg::PORT0_OUTPUT_LATCH_OFS) begin
      rd_word[7:0] = lat0_q;
    end else if (paddr_i == gpio_pkg::PORT0_PIN_INPUT_OFS) begin
      rd_word[7:0] = snap0_q;
      addr_ro = 1'b1;
    end else if (paddr_i == gpio_pkg::PORT1_OUTPUT_LATCH_OFS) begin
      rd_word[5:0] = port1_view;
    end else if (paddr_i == gpio_pkg::PORT1_DIRECTION_CONTROL_OFS) begin
      rd_word[5:0] = dir1_q;
    end else if (paddr_i == gpio_pkg::EXT_INT_CONTROL_OFS) begin
      rd_word[gpio_pkg::EXT_EXTERNAL_INTERRUPT_ZERO_EN_BIT] = external_interrupt_zero_en_q;
    end else if (paddr_i == gpio_pkg::BIT_OP_OFS) begin
      rd_word = 32'h0000_0000; // write-only command
    end else begin
      addr_hit = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // bit operation, read-modify-write on a single latch bit
  // ---------------------------------------------------------------
  logic [2:0] bop_idx;
  logic [1:0] bop_code;
  logic bop_port1;
  logic [7:0] bop_res0;
  logic [5:0] bop_res1;

  assign bop_idx = pwdata_i[gpio_pkg::BIT_OP_IDX_LSB +: 3];
  assign bop_code = pwdata_i[gpio_pkg::BIT_OP_CODE_LSB +: 2];
  assign bop_port1 = pwdata_i[gpio_pkg::BIT_OP_PORT_BIT];
  // on the second port indices six and seven change no bit, its latch still reloads from the mixed view

  // first port works on its latch, second port on the mixed view
  always_comb begin
    bop_res0 = lat0_q;
    bop_res1 = port1_view;
    case (bop_code)
      gpio_pkg::BIT_OP_SET: begin
        bop_res0[bop_idx] = 1'b1;
        if (bop_idx < 3'h6) begin
          bop_res1[bop_idx] = 1'b1;
        end
      end
      gpio_pkg::BIT_OP_CLEAR: begin
        bop_res0[bop_idx] = 1'b0;
        if (bop_idx < 3'h6) begin
          bop_res1[bop_idx] = 1'b0;
        end
      end
      gpio_pkg::BIT_OP_TOGGLE: begin
        bop_res0[bop_idx] = ~lat0_q[bop_idx];
        if (bop_idx < 3'h6) begin
          bop_res1[bop_idx] = ~port1_view[bop_idx];
        end
      end
      default: begin
        bop_res0 = lat0_q;
        bop_res1 = port1_view;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // bus sequencer: sample on setup, answer, then update
  // ---------------------------------------------------------------
  logic wr_ok;

  // a write lands only when byte lane zero is strobed and no error
  assign wr_ok = pwrite_i && pstrb_i[0] && !pslverr_q;

  // ---------------------------------------------------------------
  // write decode, one strobe per writable register
  // ---------------------------------------------------------------
  logic wr_lat0;
  logic wr_lat1;
  logic wr_dir1;
  logic wr_external_interrupt_zero;
  logic wr_bop;

  // refused and unmapped writes raise no strobe, so nothing moves
  always_comb begin
    wr_lat0 = 1'b0;
    wr_lat1 = 1'b0;
    wr_dir1 = 1'b0;
    wr_external_interrupt_zero = 1'b0;
    wr_bop = 1'b0;
    if (wr_ok) begin
      if (paddr_i == gpio_pkg::PORT0_OUTPUT_LATCH_OFS) begin
        wr_lat0 = 1'b1;
      end else if (paddr_i == gpio_pkg::PORT1_OUTPUT_LATCH_OFS) begin
        wr_lat1 = 1'b1;
      end else if (paddr_i == gpio_pkg::PORT1_DIRECTION_CONTROL_OFS) begin
        wr_dir1 = 1'b1;
      end else if (paddr_i == gpio_pkg::EXT_INT_CONTROL_OFS) begin
        wr_external_interrupt_zero = 1'b1;
      end else if (paddr_i == gpio_pkg::BIT_OP_OFS) begin
        wr_bop = 1'b1;
      end
    end
  end

  // next values for the sequencer and the port registers
  always_comb begin
    state_d = state_q;
    snap0_d = snap0_q;
    snap1_d = snap1_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    lat0_d = lat0_q;
    lat1_d = lat1_q;
    dir1_d = dir1_q;
    external_interrupt_zero_en_d = external_interrupt_zero_en_q;
    case (state_q)
      gpio_pkg::ST_IDLE: begin
        if (psel_i && !penable_i) begin
          // pins caught in the first state of the cycle
          snap0_d = pins0_sync;
          snap1_d = pins1_sync;
          state_d = gpio_pkg::ST_SAMPLE;
        end
      end
      gpio_pkg::ST_SAMPLE: begin
        if (psel_i && penable_i) begin
          prdata_d = pwrite_i ? 32'h0000_0000 : rd_word;
          pslverr_d = !addr_hit || (pwrite_i && addr_ro);
          pready_d = 1'b1;
          state_d = gpio_pkg::ST_UPDATE;
        end else if (!psel_i) begin
          // master gave up before the access phase: nothing happens
          state_d = gpio_pkg::ST_IDLE;
        end
      end
      gpio_pkg::ST_UPDATE: begin
        // write takes effect on the edge that completes the transfer
        state_d = gpio_pkg::ST_IDLE;
        // the second latch loads whatever the direction holds
        if (wr_lat0) begin
          lat0_d = pwdata_i[7:0];
        end
        if (wr_lat1) begin
          lat1_d = pwdata_i[5:0];
        end
        if (wr_dir1) begin
          dir1_d = pwdata_i[5:0];
        end
        if (wr_external_interrupt_zero) begin
          external_interrupt_zero_en_d = pwdata_i[gpio_pkg::EXT_EXTERNAL_INTERRUPT_ZERO_EN_BIT];
        end
        if (wr_bop && bop_port1) begin
          lat1_d = bop_res1;
        end
        if (wr_bop && !bop_port1) begin
          lat0_d = bop_res0;
        end
      end
      default: begin
        state_d = gpio_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer and port registers
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= gpio_pkg::ST_IDLE;
      snap0_q <= 8'h00;
      snap1_q <= 6'h00;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      lat0_q <= gpio_pkg::PORT0_LATCH_RST;
      lat1_q <= gpio_pkg::PORT1_LATCH_RST;
      dir1_q <= gpio_pkg::PORT1_DIR_RST;
      external_interrupt_zero_en_q <= gpio_pkg::EXT_EXTERNAL_INTERRUPT_ZERO_EN_RST;
    end else begin
      state_q <= state_d;
      snap0_q <= snap0_d;
      snap1_q <= snap1_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      lat0_q <= lat0_d;
      lat1_q <= lat1_d;
      dir1_q <= dir1_d;
      external_interrupt_zero_en_q <= external_interrupt_zero_en_d;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // first port enables follow the next latch values, second port enables the next direction
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_p0
      if (gi == 0) begin : g_int
        // bit zero released while it serves the interrupt
        assign oe0_n_d[gi] = lat0_d[gi] | external_interrupt_zero_en_d;
      end else begin : g_io
        // open drain: only a zero is driven, a one releases the pin
        assign oe0_n_d[gi] = lat0_d[gi];
      end
    end
    for (gi = 0; gi < 6; gi++) begin : g_p1
      // direction one drives, zero leaves the pin an input
      assign oe1_n_d[gi] = ~dir1_d[gi];
    end
  endgenerate

  // level follows the enable's next value, in step with the pin release
  // so bit zero is never driven while the interrupt level is up
  always_comb begin
    external_interrupt_zero_d = external_interrupt_zero_en_d & pins0_sync[0];
  end

  // pin driver registers
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      oe0_n_q <= gpio_pkg::PORT0_LATCH_RST;
      oe1_n_q <= ~gpio_pkg::PORT1_DIR_RST;
      external_interrupt_zero_q <= 1'b0;
    end else begin
      oe0_n_q <= oe0_n_d;
      oe1_n_q <= oe1_n_d;
      external_interrupt_zero_q <= external_interrupt_zero_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign port0_out_o = lat0_q;
  assign port0_oe_n_o = oe0_n_q;
  assign port1_out_o = lat1_q;
  assign port1_oe_n_o = oe1_n_q;
  assign external_interrupt_zero_o = external_interrupt_zero_q;

endmodule

// ==== rtl/pin_sync.sv ====
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // asynchronous pins in, synchronised levels out
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);

  // ---------------------------------------------------------------
  // two flip-flop synchroniser, one chain per bit
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_q;
      logic stable_q;
      // first stage is read only by the second stage
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          meta_q <= 1'b1;
          stable_q <= 1'b1;
        end else begin
          meta_q <= pin_i[gi];
          stable_q <= meta_q;
        end
      end
      assign sync_o[gi] = stable_q;
    end
  endgenerate

endmodule
